// file: core/lpwm_pkg.sv
package lpwm_pkg;

    // Clock rates in hertz
    localparam int HCLK_HZ     = 20_000_000;
    localparam int OSC_HZ      = 10_000_000;
    localparam int SYS_HZ      = 5_000_000;
    // Enable spacing in hclk cycles for the 10 MHz and 5 MHz rates
    localparam int OSC_DIV     = HCLK_HZ / OSC_HZ;
    localparam int SYS_DIV     = HCLK_HZ / SYS_HZ;
    // Input duty timeout, in milliseconds and in 10 MHz ticks
    localparam int DUTY_TMO_MS    = 24;
    localparam int DUTY_TMO_TICKS = OSC_HZ / 1000 * DUTY_TMO_MS;

    // Widths
    localparam int CNT_W  = 14;  // Generator counter, up to 8192 steps
    localparam int MEAS_W = 18;  // Input period counter, 10 MHz ticks
    localparam int VS_W   = 22;  // Frame period counter, hclk cycles
    localparam int LIM_W  = 26;  // Prescaler times frame period
    localparam int ACC_W  = 27;  // Frequency synthesiser accumulator
    localparam int CTRL_W = 17;
    localparam int SYNC_W = 22;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BRT  = 8'h04;
    localparam logic [7:0] OFF_SYNC = 8'h08;
    localparam logic [7:0] OFF_DIV  = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;

    // Control register fields
    localparam int F_BSEL   = 0;   // brightness_source_select, 2 bits
    localparam int F_PMUL   = 2;   // pll_multiplier_select, 2 bits
    localparam int F_FREQ   = 4;   // output_freq_code, 4 bits
    localparam int F_DITH   = 8;   // dither_depth, 3 bits
    localparam int F_STEADY = 11;  // steady_dither_enable
    localparam int F_PLLEN  = 12;  // pll_enable
    localparam int F_VSEN   = 13;  // vsync_source_enable
    localparam int F_PATH   = 14;  // divider_path_select
    localparam int F_RST    = 15;  // vsync_counter_restart
    localparam int F_SLOPE  = 16;  // Brightness slope in progress
    // Sync register fields
    localparam int F_SDIV   = 0;   // slow_feedback_divider, 13 bits
    localparam int F_PRE    = 16;  // sync_prescaler, 4 bits
    localparam int F_RSEL   = 20;  // Range multiplier select, 2 bits
    // Status register fields
    localparam int F_DUTY   = 0;   // Measured input duty, 16 bits
    localparam int F_RES    = 16;  // Resolution in bits, 5 bits
    localparam int F_FILT   = 21;  // External loop filter in use
    localparam int F_LOCK   = 22;  // Frame period measured

    // Reset values
    localparam logic [CTRL_W-1:0] RST_CTRL = 17'h00000;
    localparam logic [15:0]       RST_BRT  = 16'hffff;
    localparam logic [SYNC_W-1:0] RST_SYNC = 22'h010001;
    localparam logic [CNT_W-1:0]  RST_GDIV = 14'h0400;

    // Generator period at 5 MHz, per frequency code (rounded)
    localparam logic [10:0] BASE_DIV [16] = '{
        11'h400, 11'h200, 11'h174, 11'h125, 11'h100, 11'h0f1,
        11'h0e4, 11'h0d8, 11'h0cd, 11'h0c3, 11'h0ba, 11'h0b2,
        11'h0ab, 11'h0a4, 11'h092, 11'h080};
    // Resolution in bits at 5 MHz, per frequency code
    localparam logic [4:0] BASE_RES [16] = '{
        5'h0a, 5'h09, 5'h08, 5'h08, 5'h08, 5'h07, 5'h07, 5'h07,
        5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07};

    // Brightness source encodings, 00 to 11 in order
    typedef enum logic [1:0] {
        BS_DUTY, BS_PROD, BS_REG, BS_DIRECT
    } lpwm_bsrc_t;

    // Duty measurement state
    typedef struct packed {
        logic              prev;
        logic              busy;
        logic [4:0]        it;
        logic [MEAS_W-1:0] hi;
        logic [MEAS_W-1:0] per;
        logic [MEAS_W-1:0] dvs;
        logic [MEAS_W:0]   rem;
        logic [15:0]       quo;
        logic [15:0]       duty;
        logic              valid;
    } lpwm_meas_t;

    // Top level state
    typedef struct packed {
        logic [1:0]        div;
        logic              pwm_s1, pwm_s2;
        logic              vs_s1, vs_s2, vs_prev;
        logic              io_s1, io_s2;
        logic [CTRL_W-1:0] ctrl;
        logic [15:0]       brt;
        logic [SYNC_W-1:0] syncr;
        logic [CNT_W-1:0]  gdiv;
        logic              wr_pend;
        logic [7:0]        wr_addr;
        logic [31:0]       hrdata;
        logic              rdy;
        logic              resp;
        logic [15:0]       meas;
        logic [VS_W-1:0]   vs_cnt;
        logic [LIM_W-1:0]  vs_lim;
        logic              vs_ok;
        logic [ACC_W-1:0]  acc;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  thr;
        logic [3:0]        pulse;
        logic              pwm_out;
        logic              filt;
    } lpwm_state_t;

endpackage

// file: core/lpwm_duty_if.sv
`timescale 1ns/1ps
// Carries the 10 MHz sample enable and level in, measured duty out
interface lpwm_duty_if;
    logic        en10;   // 10 MHz sample enable
    logic        lvl;    // Synchronised input level
    logic [15:0] duty;   // Measured duty, full scale 16'hffff
    logic        valid;  // One-cycle pulse with a new duty
    modport meas (input en10, input lvl, output duty, output valid);
    modport user (output en10, output lvl, input duty, input valid);
endinterface

// file: core/lpwm_duty_meas.sv
`timescale 1ns/1ps
module lpwm_duty_meas
    import lpwm_pkg::*;
#(
    parameter int TMO = lpwm_pkg::DUTY_TMO_TICKS
) (
    // Clock and reset
    input wire logic    hclk,
    input wire logic    hresetn,
    // Sample in, duty out
    lpwm_duty_if.meas   m
);

    lpwm_meas_t q, n;            // State and its next value
    logic [MEAS_W:0] r2;         // Shifted remainder
    logic            qb;         // Quotient bit of this step

    // Refuse a timeout the period counter cannot hold
    if (TMO < 2 || TMO >= 2 ** MEAS_W) begin : g_chk
        $error("lpwm_duty_meas: TMO out of range");
    end

    assign m.duty  = q.duty;
    assign m.valid = q.valid;

    // Period and high time counted on 10 MHz samples, then divided
    always_comb begin
        n       = q;
        n.valid = 1'b0;
        r2      = {q.rem[MEAS_W-1:0], 1'b0};
        qb      = 1'b0;
        if (m.en10) begin
            n.prev = m.lvl;
            if (m.lvl && !q.prev) begin
                // Rising edge closes one full input period
                if (!q.busy && q.per != '0) begin
                    if (q.hi >= q.per) begin
                        n.duty  = 16'hffff;
                        n.valid = 1'b1;
                    end else begin
                        n.busy = 1'b1;
                        n.it   = 5'h10;
                        n.rem  = {1'b0, q.hi};
                        n.dvs  = q.per;
                    end
                end
                n.hi  = MEAS_W'(1);
                n.per = MEAS_W'(1);
            end else if (q.per == MEAS_W'(TMO - 1)) begin
                // No edge for too long: steady level is 0 or full
                n.duty  = m.lvl ? 16'hffff : 16'h0000;
                n.valid = 1'b1;
                n.hi    = '0;
                n.per   = '0;
            end else begin
                n.per = q.per + MEAS_W'(1);
                if (m.lvl) begin
                    n.hi = q.hi + MEAS_W'(1);
                end
            end
        end
        // One restoring division step per cycle, 16 steps
        if (q.busy) begin
            if (r2 >= {1'b0, q.dvs}) begin
                n.rem = r2 - {1'b0, q.dvs};
                qb    = 1'b1;
            end else begin
                n.rem = r2;
            end
            n.quo = {q.quo[14:0], qb};
            n.it  = q.it - 5'h01;
            if (q.it == 5'h01) begin
                n.busy  = 1'b0;
                n.duty  = {q.quo[14:0], qb};
                n.valid = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

endmodule

// file: core/lpwm_top.sv
`timescale 1ns/1ps
module lpwm_top
    import lpwm_pkg::*;
#(
    parameter int DUTY_TMO = lpwm_pkg::DUTY_TMO_TICKS
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Pins
    input  wire logic        pwm_in,
    input  wire logic        vsync,
    input  wire logic        io_supply_enable_pin,
    output logic             pwm_out,
    output logic             external_filter_select
);

    lpwm_state_t q, n;               // State and its next value
    lpwm_duty_if dif ();             // Link to the duty measurement

    logic              en10;         // 10 MHz enable
    logic              en5;          // 5 MHz enable
    logic              vs_rise;      // Frame start
    logic              addr_ok;      // Valid address phase
    logic [31:0]       rd;           // Read data for the data phase
    logic [1:0]        bsel;         // Brightness source
    logic [3:0]        freq;         // Frequency code
    logic [1:0]        mul;          // Effective multiplier code
    logic              pll_en;
    logic              vs_en;
    logic              path;
    logic              sync_md;      // Generator clock from frames
    logic              direct;       // Input passed straight through
    logic [CNT_W-1:0]  per;          // Output period in ticks
    logic              tick;         // Generator clock enable
    logic [1:0]        step;         // Counts per tick
    logic [3:0]        pre_eff;      // Prescaler, zero read as one
    logic [ACC_W-1:0]  acc_n;        // Accumulator plus increment
    logic              dtick;        // Synthesised generator tick
    logic [CNT_W:0]    sum;          // Counter after one tick
    logic [31:0]       prod;         // Duty times brightness word
    logic [15:0]       src;          // Selected brightness
    logic [2:0]        nd;           // Active dither depth
    logic [4:0]        mask;         // Dither index mask
    logic [29:0]       ext;          // Brightness scaled to period
    logic [29:0]       sc;           // Scaled with dither bits kept
    logic [3:0]        frac;         // Dither fraction
    logic [CNT_W-1:0]  thr_new;      // Next pulse width

    // Period of the generator in ticks for a code and multiplier
    function automatic logic [CNT_W-1:0] gen_period(
        input logic [3:0] f,
        input logic [1:0] m
    );
        gen_period = CNT_W'(BASE_DIV[f]) << m;
    endfunction

    // Output resolution in bits; each clock doubling adds one
    function automatic logic [4:0] res_bits(
        input logic [3:0] f,
        input logic [1:0] m
    );
        res_bits = BASE_RES[f] + 5'(m);
    endfunction

    // The two enables need 10 MHz as half of 20 MHz and 5 as half of 10
    if (OSC_DIV != 2 || SYS_DIV != 2 * OSC_DIV) begin : g_chk
        $error("lpwm_top: clock ratios not served");
    end

    // Duty measurement of the input pin
    lpwm_duty_meas #(
        .TMO     (DUTY_TMO)
    ) u_meas (
        .hclk    (hclk),
        .hresetn (hresetn),
        .m       (dif.meas)
    );

    assign dif.en10 = en10;
    assign dif.lvl  = q.pwm_s2;

    // Outputs straight from the state register
    assign hreadyout              = q.rdy;
    assign hresp                  = q.resp;
    assign hrdata                 = q.hrdata;
    assign pwm_out                = q.pwm_out;
    assign external_filter_select = q.filt;

    // Field views of the control and sync registers
    assign bsel    = q.ctrl[F_BSEL+:2];
    assign freq    = q.ctrl[F_FREQ+:4];
    assign pll_en  = q.ctrl[F_PLLEN];
    assign vs_en   = q.ctrl[F_VSEN];
    assign path    = q.ctrl[F_PATH];
    assign direct  = (bsel == BS_DIRECT);
    assign sync_md = pll_en && vs_en && !path;
    assign pre_eff = (q.syncr[F_PRE+:4] == 4'h0) ? 4'h1
                                                 : q.syncr[F_PRE+:4];

    // Clock enables from the hclk divider
    always_comb begin
        en10 = q.div[0];
        en5  = (q.div == 2'(SYS_DIV - 1));
    end

    // Generator clock choice: fixed, multiplied or frame locked
    always_comb begin
        mul  = (pll_en && path) ? q.ctrl[F_PMUL+:2] : 2'h0;
        step = 2'h1;
        // Frequency synthesiser: frame period times prescaler per
        // range multiplier times slow divider ticks
        acc_n = q.acc + (ACC_W'(q.syncr[F_SDIV+:13])
                         << q.syncr[F_RSEL+:2]);
        dtick = 1'b0;
        if (acc_n >= ACC_W'(q.vs_lim)) begin
            acc_n = acc_n - ACC_W'(q.vs_lim);
            dtick = 1'b1;
        end
        if (sync_md) begin
            // Whole timing follows the frame rate
            tick = dtick && q.vs_ok;
            per  = (q.gdiv < CNT_W'(2)) ? CNT_W'(2) : q.gdiv;
        end else begin
            per = gen_period(freq, mul);
            unique case (mul)
                2'h0: tick = en5;
                2'h1: tick = en10;
                2'h2: tick = 1'b1;
                2'h3: begin
                    tick = 1'b1;
                    step = 2'h2;         // Two counts per hclk
                end
            endcase
        end
    end

    // Brightness source and dither scaling of the next pulse
    always_comb begin
        prod = q.meas * q.brt;
        unique case (bsel)
            BS_DUTY:   src = q.meas;
            BS_PROD:   src = prod[31:16];
            BS_REG:    src = q.brt;
            BS_DIRECT: src = q.meas;
        endcase
        // Dither only in slopes unless steady dither enabled
        nd = (q.ctrl[F_DITH+:3] > 3'h4) ? 3'h4 : q.ctrl[F_DITH+:3];
        if (!(q.ctrl[F_STEADY] || q.ctrl[F_SLOPE]) || direct) begin
            nd = 3'h0;
        end
        mask = (5'h01 << nd) - 5'h01;
        ext  = 30'(src) * 30'(per);
        sc   = ext >> (5'h10 - 5'(nd));
        frac = sc[3:0] & mask[3:0];
        // Pulses whose index falls below the fraction get 1 LSB more
        thr_new = CNT_W'(sc >> nd)
                + CNT_W'((q.pulse & mask[3:0]) < frac);
    end

    // Registers, bus, frame tracking and the output counter
    always_comb begin
        n      = q;
        n.div  = q.div + 2'h1;
        n.rdy  = 1'b1;
        n.resp = 1'b0;
        // Two-flop synchronisers for the pins
        n.pwm_s1  = pwm_in;
        n.pwm_s2  = q.pwm_s1;
        n.vs_s1   = vsync;
        n.vs_s2   = q.vs_s1;
        n.vs_prev = q.vs_s2;
        n.io_s1   = io_supply_enable_pin;
        n.io_s2   = q.io_s1;
        vs_rise   = q.vs_s2 && !q.vs_prev;
        // Latest measured duty
        if (dif.valid) begin
            n.meas = dif.duty;
        end
        // Loop filter selection follows the divider path
        n.filt = sync_md;

        // Write data phase lands in the register file
        if (q.wr_pend) begin
            unique case (q.wr_addr)
                OFF_CTRL: n.ctrl  = hwdata[CTRL_W-1:0];
                OFF_BRT:  n.brt   = hwdata[15:0];
                OFF_SYNC: n.syncr = hwdata[SYNC_W-1:0];
                OFF_DIV:  n.gdiv  = hwdata[CNT_W-1:0];
                default:  ; // Unmapped or read-only: ignored
            endcase
        end
        // Address phase; reads see a write in its data phase
        addr_ok   = hsel && htrans[1] && hready;
        n.wr_pend = addr_ok && hwrite && (haddr[31:8] == 24'h000000);
        n.wr_addr = haddr[7:0];
        rd = 32'h00000000;
        unique case (haddr[7:0])
            OFF_CTRL: rd[CTRL_W-1:0] = n.ctrl;
            OFF_BRT:  rd[15:0]       = n.brt;
            OFF_SYNC: rd[SYNC_W-1:0] = n.syncr;
            OFF_DIV:  rd[CNT_W-1:0]  = n.gdiv;
            OFF_STAT: begin
                rd[F_DUTY+:16] = q.meas;
                rd[F_RES+:5]   = res_bits(freq, mul);
                rd[F_FILT]     = q.filt;
                rd[F_LOCK]     = q.vs_ok;
            end
            default: ; // Unmapped reads as zero
        endcase
        if (addr_ok && !hwrite) begin
            n.hrdata = (haddr[31:8] == 24'h000000) ? rd : 32'h00000000;
        end

        // Frame period in hclk cycles, times the prescaler
        if (vs_rise) begin
            n.vs_lim = LIM_W'(pre_eff) * LIM_W'(q.vs_cnt);
            n.vs_ok  = (q.vs_cnt != '0);
            n.vs_cnt = VS_W'(1);
            n.acc    = '0; // Phase aligned to the frame
        end else begin
            if (q.vs_cnt != '1) begin
                n.vs_cnt = q.vs_cnt + VS_W'(1);
            end else begin
                n.vs_ok = 1'b0; // Frames lost
            end
            n.acc = sync_md ? acc_n : '0;
        end

        // Output counter, held idle while the supply enable is low
        sum = (CNT_W + 1)'(q.cnt) + (CNT_W + 1)'(step);
        if (!q.io_s2) begin
            n.cnt     = '0;
            n.pwm_out = 1'b0;
        end else begin
            if (q.ctrl[F_RST] && vs_rise) begin
                // Frame start restarts the period
                n.cnt   = '0;
                n.thr   = thr_new;
                n.pulse = q.pulse + 4'h1;
            end else if (tick) begin
                if (sum >= (CNT_W + 1)'(per)) begin
                    n.cnt   = CNT_W'(sum - (CNT_W + 1)'(per));
                    n.thr   = thr_new;
                    n.pulse = q.pulse + 4'h1;
                end else begin
                    n.cnt = CNT_W'(sum);
                end
            end
            if (direct) begin
                // Input resampled on the generator clock
                if (tick) begin
                    n.pwm_out = q.pwm_s2;
                end
            end else begin
                n.pwm_out = (q.cnt < q.thr);
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q       <= '0;
            q.ctrl  <= RST_CTRL;
            q.brt   <= RST_BRT;
            q.syncr <= RST_SYNC;
            q.gdiv  <= RST_GDIV;
            q.rdy   <= 1'b1;
        end else begin
            q <= n;
        end
    end

endmodule

// file: verif/lpwm_vsync_src.sv
`timescale 1ns/1ps
// Frame strobe from the timing controller, free running from time zero
module lpwm_vsync_src #(
    parameter int PER_NS = 73000  // Frame period, not a multiple of PWM
) (
    // Frame strobe
    output logic vsync
);
    // Runs before and while the supply enable is high
    initial begin
        vsync = 1'b0;
        forever begin
            #(PER_NS - 1000) vsync = 1'b1;
            #1000 vsync = 1'b0;
        end
    end
endmodule

// file: verif/lpwm_top_asserts.sv
`timescale 1ns/1ps
module lpwm_top_asserts
    import lpwm_pkg::*;
#(
    parameter int DUTY_TMO = 200
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic        pwm_in,
    input wire logic        vsync,
    input wire logic        io_supply_enable_pin,
    input wire logic        pwm_out,
    input wire logic        external_filter_select
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        ap_q, aw_q;      // Address phase taken, and its direction
    logic [7:0]  aa_q;            // Its offset, 8'hff when high bits set
    logic [31:0] ctrl_q, brt_q;   // Shadow of control and brightness words
    logic [13:0] wc_q;            // Cycles since the last write, saturating
    // Follows the bus to shadow the written words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= 1'b0;
            aw_q <= 1'b0;
            aa_q <= 8'h00;
            ctrl_q <= 32'h0;
            brt_q <= 32'hffff;
            wc_q <= 14'h0;
        end else begin
            ap_q <= hsel && htrans[1] && hready;
            aw_q <= hwrite;
            aa_q <= (haddr[31:8] != 24'h0) ? 8'hff : haddr[7:0];
            if (ap_q && aw_q && aa_q == OFF_CTRL) ctrl_q <= hwdata;
            if (ap_q && aw_q && aa_q == OFF_BRT) brt_q <= hwdata;
            wc_q <= (ap_q && aw_q) ? 14'h0 : wc_q + 14'(wc_q != 14'h3fff);
        end
    end
    ready_high_a: assert property (hreadyout)
        else $error("slave inserted a wait");
    resp_okay_a: assert property (!hresp)
        else $error("slave gave an error response");
    io_off_a: assert property ((!io_supply_enable_pin)[*6] |-> !pwm_out)
        else $error("output active with supply enable low");
    filt_match_a: assert property (wc_q >= 14'd3 |->
        external_filter_select == (ctrl_q[12] & ctrl_q[13] & !ctrl_q[14]))
        else $error("filter select does not match path");
    stat_filter_a: assert property (ap_q && !aw_q && aa_q == OFF_STAT
        && wc_q >= 14'd2 |-> hrdata[21] == external_filter_select)
        else $error("status filter bit differs from pin");
    unmapped_zero_a: assert property (ap_q && !aw_q && aa_q > OFF_STAT
        |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    dark_zero_a: assert property (wc_q >= 14'h2100 && ctrl_q[1:0] == 2'b10
        && brt_q[15:0] == 16'h0 && ctrl_q[10:8] == 3'h0 |-> !pwm_out)
        else $error("output high at zero brightness");
    direct_follow_a: assert property ((io_supply_enable_pin && wc_q >= 14'd3
        && ctrl_q[1:0] == 2'b11 && $stable(pwm_in))[*8] |-> pwm_out == pwm_in)
        else $error("direct output does not follow input");
    cover property (ctrl_q[1:0] == 2'b11 && pwm_out);
    cover property (external_filter_select);
    cover property (ap_q && !aw_q && aa_q > OFF_STAT);
endmodule

// file: verif/lpwm_top_tb.sv
`timescale 1ns/1ps
module lpwm_top_tb;
    import lpwm_pkg::*;
    logic        hclk = 0, hresetn = 0, hwrite = 0;  // Clock, reset, bus
    logic        pwm_in = 0, io_en = 0;              // Pin drives
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    wire  logic  hreadyout, hresp, pwm_out, filt, vsync;
    wire  logic [31:0] hrdata;
    int n_errors = 0, samples_checked = 0, cyc = 0, pc = 0, h, p;
    logic [7:0]  ra [5] = '{OFF_CTRL, OFF_BRT, OFF_SYNC, OFF_DIV, 8'h14};
    logic [31:0] rv [5] = '{32'h0, 32'hffff, 32'h10001, 32'h400, 32'h0};
    // Control words with expected resolution and period in hclk cycles
    logic [31:0] fc [5] = '{32'hf2, 32'h5002, 32'h501a, 32'h5046, 32'h50fe};
    int fr [5] = '{7, 10, 11, 9, 10};
    int fp [5] = '{512, 4096, 2048, 1024, 512};
    always #25 hclk = ~hclk;
    // Input pulse: 400 cycle period, 100 cycles high
    always @(posedge hclk) begin
        pc <= (pc == 399) ? 0 : pc + 1;
        pwm_in <= (pc < 100);
    end
    // Hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_errors++;
            wrap_up();
        end
    end
    lpwm_top #(.DUTY_TMO(1000)) lpwm_top_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pwm_in(pwm_in), .vsync(vsync), .io_supply_enable_pin(io_en),
        .pwm_out(pwm_out), .external_filter_select(filt));
    lpwm_vsync_src lpwm_vsync_src_inst (.vsync(vsync));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One single transfer; read data lands in rd
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // High time and period of one output pulse, bounded
    task meas(output int hi, output int per);
        int k;
        k = 0;
        hi = 0;
        while (pwm_out !== 1'b0 && k < 20000) begin @(posedge hclk); k++; end
        while (pwm_out !== 1'b1 && k < 20000) begin @(posedge hclk); k++; end
        while (pwm_out === 1'b1 && k < 20000) begin @(posedge hclk); hi++; k++; end
        per = hi;
        while (pwm_out !== 1'b1 && k < 20000) begin @(posedge hclk); per++; k++; end
    endtask
    task wrap_up();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        io_en <= 1'b1;  // Frame source already running
        foreach (ra[i]) begin
            bus(0, ra[i], 0);
            chk("reset value", rd, rv[i]);
        end
        bus(1, OFF_STAT, 32'hffffffff);  // Read-only word ignores writes
        bus(0, OFF_STAT, 0);
        chk("stat res", 32'(rd[20:16]), 10);
        bus(1, OFF_BRT, 32'h8000);
        // Frequency code and multiplier sweep at half brightness
        foreach (fc[i]) begin
            bus(1, OFF_CTRL, fc[i]);
            bus(0, OFF_STAT, 0);
            chk("resolution", 32'(rd[20:16]), fr[i]);
            meas(h, p);
            meas(h, p);
            chk("period", p, fp[i]);
            chk("high", h, fp[i] / 2);
        end
        // Frame edge restarts the counter: high after it, low by mid period
        bus(1, OFF_CTRL, 32'h80f2);
        meas(h, p);
        repeat (3) begin
            @(posedge vsync);
            repeat (12) @(posedge hclk);
            chk("restart hi", pwm_out, 1);
            repeat (258) @(posedge hclk);
            chk("restart lo", pwm_out, 0);
        end
        bus(1, OFF_CTRL, 32'h3);
        meas(h, p);
        meas(h, p);
        chk("direct hi", h, 100);
        chk("direct per", p, 400);
        io_en <= 1'b0;
        repeat (20) @(posedge hclk);
        chk("io off", pwm_out, 0);
        io_en <= 1'b1;
        bus(1, OFF_CTRL, 32'hf0);
        bus(0, OFF_STAT, 0);
        chk("duty", 32'(rd[15:0] >= 16'h3ffe && rd[15:0] <= 16'h4001), 1);
        meas(h, p);
        meas(h, p);
        chk("duty hi", 32'(h == 128 || h == 124), 1);
        bus(1, OFF_CTRL, 32'hf1);
        meas(h, p);
        meas(h, p);
        chk("product hi", 32'(h >= 60 && h <= 64), 1);
        bus(1, OFF_CTRL, 32'h3000);
        bus(0, OFF_STAT, 0);
        chk("filt stat", 32'(rd[21]), 1);
        chk("filt pin", filt, 1);
        bus(1, OFF_CTRL, 32'h7000);
        bus(0, OFF_STAT, 0);
        chk("filt off", 32'(rd[21]), 0);
        // Frame locked: 1460 cycle frame, 1460 ticks per frame, divisor 146
        bus(1, OFF_SYNC, 32'h105b4);  // Synthesised 20 MHz
        bus(1, OFF_DIV, 32'd146);
        bus(1, OFF_CTRL, 32'h3002);
        meas(h, p);
        meas(h, p);
        chk("sync per", p, 146);
        chk("sync hi", h, 73);
        bus(1, OFF_BRT, 0);
        bus(1, OFF_CTRL, 32'h2);
        repeat (9000) @(posedge hclk);
        h = 0;
        repeat (4096) begin
            @(posedge hclk);
            h += int'(pwm_out !== 1'b0);
        end
        chk("dark", h, 0);
        wrap_up();
    end
endmodule
bind lpwm_top lpwm_top_asserts #(.DUTY_TMO(DUTY_TMO)) lpwm_top_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pwm_in(pwm_in), .vsync(vsync),
    .io_supply_enable_pin(io_supply_enable_pin), .pwm_out(pwm_out),
    .external_filter_select(external_filter_select));
